// *** fuse_array_model.sv ***
// Purpose: Behavioural fuse array answering senses and burns
// Assumes: Sense answer after lat idle cycles
// Notes:   Read data toggles outside the answer cycle
`timescale 1ns/100ps
module fuse_array_model (
	input  wire logic       mclk,
	input  wire logic [6:0] fuse_row,
	input  wire logic       fuse_sense_req,
	input  wire logic       fuse_prog_en,
	input  wire logic [2:0] fuse_prog_bit,
	output logic      [7:0] fuse_rdata,
	output logic            fuse_sense_done
);
	logic [7:0] mem [0:31] = '{default: 8'h00};
	int         lat = 2;
	int         cnt = 0;
	logic       pen_d = 1'b0;
	initial begin
		fuse_rdata = 8'hA5;
		fuse_sense_done = 1'b0;
	end
	// Sense answer and burn on pulse start
	always @(posedge mclk) begin
		fuse_sense_done <= 1'b0;
		fuse_rdata <= ~fuse_rdata;
		pen_d <= fuse_prog_en;
		if (fuse_prog_en && !pen_d) mem[fuse_row[6:2]][fuse_prog_bit] <= 1'b1;
		if (fuse_sense_req && !fuse_sense_done) begin
			if (cnt >= lat) begin
				fuse_sense_done <= 1'b1;
				fuse_rdata <= mem[fuse_row[6:2]];
				cnt <= 0;
			end else cnt <= cnt + 1;
		end
	end
endmodule : fuse_array_model

// *** fuse_bank_protection_control.sv ***
// Purpose: Protection and lock enforcement for fuse bank 0
// Assumes: Fuse array on mclk; sense done is a one-cycle pulse
// Notes:   AXI4-Lite register slave, one write and one read at a time
`timescale 1ns/100ps
`include "fuse_params.svh"
module fuse_bank_protection_control (
	input  wire logic        mclk,
	input  wire logic        reset,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Fuse array
	output logic [6:0]       fuse_row,
	output logic             fuse_sense_req,
	output logic [1:0]       fuse_sense_mode,
	output logic             fuse_prog_en,
	output logic [2:0]       fuse_prog_bit,
	input  wire logic [7:0]  fuse_rdata,
	input  wire logic        fuse_sense_done,
	// Debug security
	output logic             debug_controller_clk_en,
	output logic [1:0]       debug_security_level
);
	fuse_pkg::ctl_state_t state_ff;
	fuse_pkg::ctl_state_t nxt_state;
	logic [7:0]  prot_row_ff;
	logic [7:0]  dbg_row_ff;
	logic        ready_ff;
	logic [6:0]  addr_row_ff;
	logic [2:0]  addr_bit_ff;
	logic [2:0]  pgm_len_ff;
	logic [7:0]  ovr_wdata_ff;
	logic [7:0]  data_ff;
	logic        refused_ff;
	logic        done_ff;
	logic [6:0]  fuse_row_ff;
	logic [1:0]  sense_mode_ff;
	logic        read_op_ff;
	logic [1:0]  dbg_level_ff;
	logic [7:0]  ovr_mem [0:31];
	logic [31:0] ovr_valid_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rdata_ff;
	logic        wr_fire;
	logic        rd_fire;
	logic        cmd_req;
	logic [2:0]  cmd_op;
	logic        deny;
	logic        grant;
	logic        locked;
	logic        timer_start;
	logic        timer_busy;
	logic        timer_done;
	logic        clr_refused;
	logic        clr_done;

	// Lock coverage of a row address
	function automatic logic row_locked(input logic [6:0] row,
	                                     input logic [7:0] prot);
		logic hit;
		hit = 1'b0;
		if (prot[`BIT_TESTER_LOCK] && row >= 7'h1C && row <= 7'h3C) begin
			hit = 1'b1;
		end
		if (prot[`BIT_NET_LOCK] && row >= 7'h68 && row <= 7'h7C) begin
			hit = 1'b1;
		end
		if (prot[`BIT_TRIM_LOCK] && (row == 7'h08 ||
		    (row >= 7'h54 && row <= 7'h64))) begin
			hit = 1'b1;
		end
		if (prot[`BIT_BOOT_LOCK] && (row == 7'h04 ||
		    (row >= 7'h0C && row <= 7'h18) ||
		    (row >= 7'h40 && row <= 7'h44))) begin
			hit = 1'b1;
		end
		return hit;
	endfunction : row_locked

	// Write and read handshakes
	assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	assign rd_fire       = s_axi_arvalid && !rvalid_ff;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready  = wr_fire;
	assign s_axi_arready = !rvalid_ff;

	// Register write strobes
	assign cmd_req     = wr_fire && s_axi_wstrb[0] &&
	                     (s_axi_awaddr == `REG_CMD);
	assign cmd_op      = s_axi_wdata[2:0];
	assign clr_refused = wr_fire && s_axi_wstrb[0] &&
	                     (s_axi_awaddr == `REG_STATUS) &&
	                     s_axi_wdata[`ST_BIT_REFUSED];
	assign clr_done    = wr_fire && s_axi_wstrb[0] &&
	                     (s_axi_awaddr == `REG_STATUS) &&
	                     s_axi_wdata[`ST_BIT_DONE];

	// Access decision for a requested operation
	assign locked = row_locked(addr_row_ff, prot_row_ff);
	always_comb begin
		deny = 1'b1;
		case (cmd_op)
			fuse_pkg::OP_READ: begin
				deny = prot_row_ff[`BIT_READ_PROT];
			end
			fuse_pkg::OP_SENSE, fuse_pkg::OP_SENSE_ZERO,
			fuse_pkg::OP_SENSE_ONE: begin
				deny = prot_row_ff[`BIT_SENSE_PROT];
			end
			fuse_pkg::OP_PROGRAM: begin
				deny = prot_row_ff[`BIT_WRITE_PROT] || locked ||
				       (pgm_len_ff < 3'(`PGM_MIN_LEN));
			end
			fuse_pkg::OP_OVERRIDE: begin
				deny = prot_row_ff[`BIT_OVR_PROT] || locked;
			end
			default: begin
				deny = 1'b1;
			end
		endcase
	end
	// Nothing is granted before the boot rows are latched
	assign grant = cmd_req && !deny && ready_ff &&
	               (state_ff == fuse_pkg::ST_IDLE);
	assign timer_start = grant && (cmd_op == fuse_pkg::OP_PROGRAM);

	// Controller sequence
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			fuse_pkg::ST_BOOT_PROT: begin
				if (fuse_sense_done) begin
					nxt_state = fuse_pkg::ST_BOOT_DBG;
				end
			end
			fuse_pkg::ST_BOOT_DBG: begin
				if (fuse_sense_done) begin
					nxt_state = fuse_pkg::ST_IDLE;
				end
			end
			fuse_pkg::ST_IDLE: begin
				if (grant && cmd_op == fuse_pkg::OP_PROGRAM) begin
					nxt_state = fuse_pkg::ST_PROG;
				end else if (grant && cmd_op != fuse_pkg::OP_OVERRIDE) begin
					nxt_state = fuse_pkg::ST_SENSE;
				end
			end
			fuse_pkg::ST_SENSE: begin
				if (fuse_sense_done) begin
					nxt_state = fuse_pkg::ST_IDLE;
				end
			end
			fuse_pkg::ST_PROG: begin
				if (timer_done) begin
					nxt_state = fuse_pkg::ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_ff <= fuse_pkg::ST_BOOT_PROT;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Boot sensing of protection and debug rows
	always_ff @(posedge mclk) begin
		if (reset) begin
			prot_row_ff <= 8'hFF;
			dbg_row_ff  <= 8'hFF;
			ready_ff    <= 1'b0;
		end else if (fuse_sense_done) begin
			if (state_ff == fuse_pkg::ST_BOOT_PROT) begin
				prot_row_ff <= fuse_rdata;
			end
			if (state_ff == fuse_pkg::ST_BOOT_DBG) begin
				dbg_row_ff <= fuse_rdata;
				ready_ff   <= 1'b1;
			end
		end
	end

	// Row and mode presented to the array, and the read operation flag
	always_ff @(posedge mclk) begin
		if (reset) begin
			fuse_row_ff   <= `ROW_PROTECT;
			sense_mode_ff <= 2'h0;
			read_op_ff    <= 1'b0;
		end else if (state_ff == fuse_pkg::ST_BOOT_PROT &&
		             fuse_sense_done) begin
			fuse_row_ff <= `ROW_DEBUG;
		end else if (grant) begin
			fuse_row_ff   <= addr_row_ff;
			read_op_ff    <= (cmd_op == fuse_pkg::OP_READ);
			sense_mode_ff <= (cmd_op == fuse_pkg::OP_READ) ? 2'h0 :
			                 2'(cmd_op - 3'h1);
		end
	end

	// Software registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			addr_row_ff  <= 7'h00;
			addr_bit_ff  <= 3'h0;
			pgm_len_ff   <= `PGM_LEN_RST;
			ovr_wdata_ff <= 8'h00;
		end else if (wr_fire) begin
			if (s_axi_awaddr == `REG_ADDR && s_axi_wstrb[0]) begin
				addr_row_ff <= {s_axi_wdata[6:2], 2'h0};
			end
			if (s_axi_awaddr == `REG_ADDR && s_axi_wstrb[1]) begin
				addr_bit_ff <= s_axi_wdata[10:8];
			end
			if (s_axi_awaddr == `REG_PGM_LEN && s_axi_wstrb[0]) begin
				pgm_len_ff <= s_axi_wdata[2:0];
			end
			if (s_axi_awaddr == `REG_DATA && s_axi_wstrb[0]) begin
				ovr_wdata_ff <= s_axi_wdata[7:0];
			end
		end
	end

	// Override store, replaces sensed values on software reads
	always_ff @(posedge mclk) begin
		if (grant && cmd_op == fuse_pkg::OP_OVERRIDE) begin
			ovr_mem[addr_row_ff[6:2]] <= ovr_wdata_ff;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ovr_valid_ff <= 32'h00000000;
		end else if (grant && cmd_op == fuse_pkg::OP_OVERRIDE) begin
			ovr_valid_ff[addr_row_ff[6:2]] <= 1'b1;
		end
	end

	// Data of the last read or sense
	always_ff @(posedge mclk) begin
		if (reset) begin
			data_ff <= 8'h00;
		end else if (state_ff == fuse_pkg::ST_SENSE && fuse_sense_done) begin
			if (read_op_ff && ovr_valid_ff[fuse_row_ff[6:2]]) begin
				data_ff <= ovr_mem[fuse_row_ff[6:2]];
			end else begin
				data_ff <= fuse_rdata;
			end
		end
	end

	// Sticky refused and done flags, set wins over clear
	always_ff @(posedge mclk) begin
		if (reset) begin
			refused_ff <= 1'b0;
			done_ff    <= 1'b0;
		end else begin
			if (cmd_req && !grant) begin
				refused_ff <= 1'b1;
			end else if (clr_refused) begin
				refused_ff <= 1'b0;
			end
			if ((state_ff == fuse_pkg::ST_SENSE && fuse_sense_done) ||
			    timer_done ||
			    (grant && cmd_op == fuse_pkg::OP_OVERRIDE)) begin
				done_ff <= 1'b1;
			end else if (clr_done) begin
				done_ff <= 1'b0;
			end
		end
	end

	// Debug security decode, undefined code treated as no debug
	always_ff @(posedge mclk) begin
		if (reset) begin
			dbg_level_ff <= fuse_pkg::DBG_NONE;
		end else begin
			unique case (dbg_row_ff[`DBG_LVL_HI:`DBG_LVL_LO])
				2'h0:    dbg_level_ff <= fuse_pkg::DBG_OPEN;
				2'h1:    dbg_level_ff <= fuse_pkg::DBG_SECURED;
				default: dbg_level_ff <= fuse_pkg::DBG_NONE;
			endcase
		end
	end

	// Write response
	always_ff @(posedge mclk) begin
		if (reset) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			if (s_axi_awaddr == `REG_CMD || s_axi_awaddr == `REG_ADDR ||
			    s_axi_awaddr == `REG_PGM_LEN ||
			    s_axi_awaddr == `REG_DATA ||
			    s_axi_awaddr == `REG_STATUS) begin
				bresp_ff <= `RESP_OKAY;
			end else begin
				bresp_ff <= `RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Read response
	always_ff @(posedge mclk) begin
		if (reset) begin
			rvalid_ff <= 1'b0;
			rresp_ff  <= `RESP_OKAY;
			rdata_ff  <= 32'h00000000;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= `RESP_OKAY;
			unique case (s_axi_araddr)
				`REG_CMD:      rdata_ff <= 32'h00000000;
				`REG_ADDR:     rdata_ff <= {21'h0, addr_bit_ff,
				                            1'b0, addr_row_ff};
				`REG_PGM_LEN:  rdata_ff <= {29'h0, pgm_len_ff};
				`REG_DATA:     rdata_ff <= {24'h0, data_ff};
				`REG_STATUS:   rdata_ff <= {28'h0, done_ff, refused_ff,
				                            ready_ff,
				                            (state_ff != fuse_pkg::ST_IDLE)};
				`REG_PROT_ROW: rdata_ff <= {24'h0, prot_row_ff};
				`REG_DBG_ROW:  rdata_ff <= {22'h0, dbg_level_ff, dbg_row_ff};
				default: begin
					rdata_ff <= 32'h00000000;
					rresp_ff <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// Programming pulse timer
	pgm_pulse_timer u_timer (
		.mclk   (mclk),
		.reset  (reset),
		.start  (timer_start),
		.length (pgm_len_ff),
		.busy   (timer_busy),
		.done   (timer_done)
	);

	// Outputs
	assign s_axi_bvalid    = bvalid_ff;
	assign s_axi_bresp     = bresp_ff;
	assign s_axi_rvalid    = rvalid_ff;
	assign s_axi_rresp     = rresp_ff;
	assign s_axi_rdata     = rdata_ff;
	assign fuse_row        = fuse_row_ff;
	assign fuse_sense_mode = sense_mode_ff;
	assign fuse_sense_req  = (state_ff == fuse_pkg::ST_BOOT_PROT) ||
	                         (state_ff == fuse_pkg::ST_BOOT_DBG) ||
	                         (state_ff == fuse_pkg::ST_SENSE);
	assign fuse_prog_en    = timer_busy;
	assign fuse_prog_bit   = addr_bit_ff;
	// Debug clock held off until rows are known
	assign debug_controller_clk_en = ready_ff &&
	                                 !dbg_row_ff[`BIT_DBG_OFF];
	assign debug_security_level    = dbg_level_ff;
endmodule : fuse_bank_protection_control

// *** fuse_bank_protection_control_props.sv ***
// Purpose: Concurrent checks on the fuse protection ports
// Assumes: Boot senses row 0, then row 4
// Notes:   Shadows latch the boot rows from the array bus
`timescale 1ns/100ps
module fuse_bank_protection_control_props (
	input wire logic       mclk,
	input wire logic       reset,
	input wire logic [6:0] fuse_row,
	input wire logic       fuse_sense_req,
	input wire logic [1:0] fuse_sense_mode,
	input wire logic       fuse_prog_en,
	input wire logic [7:0] fuse_rdata,
	input wire logic       fuse_sense_done,
	input wire logic       debug_controller_clk_en,
	input wire logic [1:0] debug_security_level
);
	logic [1:0]  boot_ff;
	logic [7:0]  prot_ff;
	logic [7:0]  dbg_ff;
	logic [11:0] plen_ff;
	logic        booted;
	logic [1:0]  exp_lvl;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// Boot row shadows
	always_ff @(posedge mclk) begin
		if (reset) begin
			boot_ff <= 2'h0;
		end else if (fuse_sense_done && !booted) begin
			boot_ff <= boot_ff + 2'h1;
			if (boot_ff == 2'h0) prot_ff <= fuse_rdata;
			else dbg_ff <= fuse_rdata;
		end
	end
	// Pulse length counter
	always_ff @(posedge mclk) begin
		if (reset || !fuse_prog_en) plen_ff <= 12'h000;
		else plen_ff <= plen_ff + 12'h001;
	end
	assign booted = (boot_ff == 2'h2);
	// Level field 00 open, 01 secured, 11 none; unused 10 reads as none
	assign exp_lvl = (dbg_ff[6:5] == 2'h2) ? 2'h3 : dbg_ff[6:5];
	function automatic logic locked(input logic [6:0] r,
		input logic [7:0] p);
		locked = (p[4] && r >= 7'h1C && r <= 7'h3C) || (p[2] && r >= 7'h68)
			|| (p[1] && (r == 7'h08 || (r >= 7'h54 && r <= 7'h64)))
			|| (p[0] && (r == 7'h04 || (r >= 7'h0C && r <= 7'h18)
			|| r == 7'h40 || r == 7'h44));
	endfunction : locked
	AST_BOOT_ROWS: assert property (fuse_sense_req && !booted
		|-> fuse_row == (boot_ff[0] ? 7'h04 : 7'h00))
		else $error("boot sense on wrong row");
	AST_NO_EARLY: assert property (!booted |-> !fuse_prog_en)
		else $error("program before boot");
	AST_WP: assert property ($rose(fuse_prog_en) |-> !prot_ff[7])
		else $error("program while write protected");
	AST_LOCK: assert property ($rose(fuse_prog_en) |->
		!locked(fuse_row, prot_ff)) else $error("program of locked row");
	AST_SENSE: assert property (booted && $rose(fuse_sense_req)
		&& fuse_sense_mode != 2'h0 |-> !prot_ff[3])
		else $error("stress sense while protected");
	AST_RD_SENSE: assert property (booted && $rose(fuse_sense_req)
		|-> !(prot_ff[3] && prot_ff[5])) else $error("array access denied");
	AST_PLEN: assert property ($fell(fuse_prog_en) |->
		plen_ff >= 12'd1252 && plen_ff % 12'd313 == 12'd0)
		else $error("pulse length wrong");
	AST_PMAX: assert property (fuse_prog_en |-> plen_ff < 12'd2191)
		else $error("pulse too long");
	AST_CLK: assert property (booted && $past(booted) |->
		debug_controller_clk_en == !dbg_ff[7]) else $error("debug clock");
	AST_LVL: assert property (booted && $past(booted) |->
		debug_security_level == exp_lvl) else $error("debug level");
	AST_LVL_BOOT: assert property (!booted |-> debug_security_level
		== 2'h3 && !debug_controller_clk_en) else $error("debug open early");
	COV_PULSE: cover property ($fell(fuse_prog_en));
	COV_ONE: cover property (booted && fuse_sense_req && fuse_sense_mode == 2'h2);
	COV_NONE: cover property (booted && debug_security_level == 2'h3);
endmodule : fuse_bank_protection_control_props
bind fuse_bank_protection_control fuse_bank_protection_control_props u_props (
	.mclk(mclk), .reset(reset), .fuse_row(fuse_row),
	.fuse_sense_req(fuse_sense_req), .fuse_sense_mode(fuse_sense_mode),
	.fuse_prog_en(fuse_prog_en), .fuse_rdata(fuse_rdata),
	.fuse_sense_done(fuse_sense_done),
	.debug_controller_clk_en(debug_controller_clk_en),
	.debug_security_level(debug_security_level));

// *** fuse_bank_protection_control_tb.sv ***
// Purpose: Self-checking bench for fuse protection control
// Assumes: Array model with settable sense latency
// Notes:   Three boots with different protection rows
`timescale 1ns/100ps
`include "fuse_params.svh"
module fuse_bank_protection_control_tb;
	localparam logic [1:0] DONE = 2'h2;
	localparam logic [1:0] REFD = 2'h1;
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, lvl, smode;
	logic [31:0] rdata;
	logic [6:0]  row;
	logic        sreq, sdone, pen, clk_en;
	logic [2:0]  pbit;
	logic [7:0]  frd;
	int          n_mismatch = 0;
	int          check_count = 0;
	always #50 mclk = ~mclk;
	fuse_bank_protection_control dut (.mclk(mclk), .reset(reset),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .fuse_row(row),
		.fuse_sense_req(sreq), .fuse_sense_mode(smode), .fuse_prog_en(pen),
		.fuse_prog_bit(pbit), .fuse_rdata(frd), .fuse_sense_done(sdone),
		.debug_controller_clk_en(clk_en), .debug_security_level(lvl));
	fuse_array_model arr (.mclk(mclk), .fuse_row(row),
		.fuse_sense_req(sreq), .fuse_prog_en(pen), .fuse_prog_bit(pbit),
		.fuse_rdata(frd), .fuse_sense_done(sdone));
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(posedge mclk);
		while (awready !== 1'b1) @(posedge mclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(posedge mclk);
		while (bvalid !== 1'b1) @(posedge mclk);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge mclk);
		while (arready !== 1'b1) @(posedge mclk);
		arvalid <= 1'b0;
		@(posedge mclk);
		while (rvalid !== 1'b1) @(posedge mclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk32
	task automatic chk2(input logic [1:0] g, input logic [1:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: code %h not %h", $time, g, e);
		end
	endtask : chk2
	// Issue one command, wait idle, return done and refused bits
	task automatic op(input logic [6:0] rw, input logic [2:0] b,
		input fuse_pkg::fuse_op_t c, output logic [1:0] st);
		logic [31:0] s;
		logic [1:0]  r;
		wr(`REG_ADDR, {21'h0, b, 1'b0, rw}, r);
		wr(`REG_CMD, {29'h0, c}, r);
		for (int i = 0; i < 4000; i++) begin
			rd(`REG_STATUS, s, r);
			if (s[0] === 1'b0) break;
		end
		st = s[3:2];
		wr(`REG_STATUS, 32'h0000000C, r);
	endtask : op
	task automatic boot(input logic [7:0] p, input logic [7:0] g,
		input logic [1:0] el, input logic early);
		logic [31:0] s;
		logic [1:0]  r;
		arr.mem[0] = p;
		arr.mem[1] = g;
		@(posedge mclk);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		if (early) begin
			op(7'h48, 3'h0, fuse_pkg::OP_PROGRAM, r);
			chk2(r, REFD);
		end
		for (int i = 0; i < 100; i++) begin
			rd(`REG_STATUS, s, r);
			if (s[1] === 1'b1) break;
		end
		rd(`REG_PROT_ROW, s, r);
		chk32(s, {24'h0, p});
		rd(`REG_DBG_ROW, s, r);
		chk32(s, {22'h0, el, g});
		chk2(lvl, el);
		chk2({1'b0, clk_en}, {1'b0, ~g[7]});
		rd(`REG_PGM_LEN, s, r);
		chk32(s, {29'h0, `PGM_LEN_RST});
		$display("boot %h %h done", p, g);
	endtask : boot
	task automatic t_open();
		logic [31:0] s;
		logic [1:0]  r, st;
		boot(8'h00, 8'h20, 2'h1, 1'b0);
		wr(8'h40, 32'h0, r);
		chk2(r, `RESP_SLVERR);
		rd(8'h40, s, r);
		chk2(r, `RESP_SLVERR);
		wr(`REG_PROT_ROW, 32'hFF, r);
		chk2(r, `RESP_SLVERR);
		arr.mem[8] = 8'h5A;
		op(7'h20, 3'h0, fuse_pkg::OP_READ, st);
		rd(`REG_DATA, s, r);
		chk32({s[7:0], 6'h0, st}, {8'h5A, 6'h0, DONE});
		arr.lat = 6;
		for (int m = 1; m < 4; m++) begin
			op(7'h20, 3'h0, fuse_pkg::fuse_op_t'(m[2:0]), st);
			chk2(st, DONE);
		end
		wr(`REG_DATA, 32'h33, r);
		op(7'h20, 3'h0, fuse_pkg::OP_OVERRIDE, st);
		chk2(st, DONE);
		op(7'h20, 3'h0, fuse_pkg::OP_READ, st);
		rd(`REG_DATA, s, r);
		chk32(s[7:0], 32'h33);
		wr(`REG_PGM_LEN, 32'h3, r);
		op(7'h24, 3'h2, fuse_pkg::OP_PROGRAM, st);
		chk2(st, REFD);
		wr(`REG_PGM_LEN, 32'h4, r);
		op(7'h24, 3'h2, fuse_pkg::OP_PROGRAM, st);
		chk2(st, DONE);
		chk32({24'h0, arr.mem[9]}, 32'h04);
		$display("open bank test done");
	endtask : t_open
	task automatic t_prot();
		logic [1:0] st;
		boot(8'hFF, 8'h80, 2'h0, 1'b0);
		for (int m = 0; m < 6; m++) begin
			op(7'h48, 3'h1, fuse_pkg::fuse_op_t'(m[2:0]), st);
			chk2(st, REFD);
		end
		$display("protect test done");
	endtask : t_prot
	task automatic t_lock();
		logic [6:0] lk [12] = '{7'h1C, 7'h3C, 7'h68, 7'h7C, 7'h08, 7'h54,
			7'h64, 7'h04, 7'h0C, 7'h18, 7'h40, 7'h44};
		logic [1:0] st;
		arr.lat = 40;
		boot(8'h17, 8'h60, 2'h3, 1'b1);
		for (int i = 0; i < 12; i++) begin
			op(lk[i], 3'h0, fuse_pkg::OP_PROGRAM, st);
			chk2(st, REFD);
			op(lk[i], 3'h0, fuse_pkg::OP_OVERRIDE, st);
			chk2(st, REFD);
		end
		op(7'h70, 3'h0, fuse_pkg::OP_READ, st);
		chk2(st, DONE);
		op(7'h70, 3'h0, fuse_pkg::OP_SENSE, st);
		chk2(st, DONE);
		op(7'h48, 3'h3, fuse_pkg::OP_PROGRAM, st);
		chk2(st, DONE);
		op(7'h50, 3'h3, fuse_pkg::OP_PROGRAM, st);
		chk2(st, DONE);
		$display("lock test done");
	endtask : t_lock
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	initial begin
		t_open();
		t_prot();
		t_lock();
		finish_test();
	end
	// Watchdog
	initial begin
		#3000000;
		n_mismatch++;
		finish_test();
	end
endmodule : fuse_bank_protection_control_tb

// *** fuse_params.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 10 MHz mclk, 32 kHz programming time base
// Notes:   Definitions only
`ifndef FUSE_PARAMS_SVH
`define FUSE_PARAMS_SVH

// Clock rates and programming time base
`define CLK_HZ          10000000
`define SLOW_HZ         32000
`define SLOW_DIV        ((`CLK_HZ + `SLOW_HZ - 1) / `SLOW_HZ)
`define PGM_MIN_US      125
`define PGM_MIN_LEN     ((`PGM_MIN_US * `SLOW_HZ + 999999) / 1000000)
`define PGM_LEN_RST     3'h4

// Fuse rows of bank 0
`define ROW_PROTECT     7'h00
`define ROW_DEBUG       7'h04

// Protection row fields
`define BIT_WRITE_PROT  7
`define BIT_OVR_PROT    6
`define BIT_READ_PROT   5
`define BIT_TESTER_LOCK 4
`define BIT_SENSE_PROT  3
`define BIT_NET_LOCK    2
`define BIT_TRIM_LOCK   1
`define BIT_BOOT_LOCK   0

// Debug security row fields
`define BIT_DBG_OFF     7
`define DBG_LVL_HI      6
`define DBG_LVL_LO      5

// Register byte offsets
`define REG_CMD         8'h00
`define REG_ADDR        8'h04
`define REG_PGM_LEN     8'h08
`define REG_DATA        8'h0C
`define REG_STATUS      8'h10
`define REG_PROT_ROW    8'h14
`define REG_DBG_ROW     8'h18

// Status fields
`define ST_BIT_BUSY     0
`define ST_BIT_READY    1
`define ST_BIT_REFUSED  2
`define ST_BIT_DONE     3

// Bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// *** fuse_pkg.sv ***
// Purpose: Types shared by the fuse protection logic
// Assumes: Nothing
// Notes:   Operation codes are software visible
package fuse_pkg;

	// Controller states
	typedef enum logic [2:0] {
		ST_BOOT_PROT,
		ST_BOOT_DBG,
		ST_IDLE,
		ST_SENSE,
		ST_PROG
	} ctl_state_t;

	// Software operations
	typedef enum logic [2:0] {
		OP_READ       = 3'h0,
		OP_SENSE      = 3'h1,
		OP_SENSE_ZERO = 3'h2,
		OP_SENSE_ONE  = 3'h3,
		OP_PROGRAM    = 3'h4,
		OP_OVERRIDE   = 3'h5
	} fuse_op_t;

	// Debug security levels
	typedef enum logic [1:0] {
		DBG_OPEN    = 2'h0,
		DBG_SECURED = 2'h1,
		DBG_NONE    = 2'h3
	} dbg_level_t;

endpackage : fuse_pkg

// *** pgm_pulse_timer.sv ***
// Purpose: Programming pulse of length count times the 32 kHz period
// Assumes: start only while not busy
// Notes:   Divider restarts on start so no period is short
`timescale 1ns/100ps
`include "fuse_params.svh"
module pgm_pulse_timer (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       start,
	input  wire logic [2:0] length,
	output logic            busy,
	output logic            done
);
	logic [8:0] div_ff;
	logic [2:0] ticks_ff;
	logic       busy_ff;
	logic       done_ff;
	logic       slow_tick;

	// One-cycle enable at the 32 kHz rate
	assign slow_tick = busy_ff && (div_ff == 9'(`SLOW_DIV - 1));

	// Divider of mclk
	always_ff @(posedge mclk) begin
		if (reset || start || slow_tick) begin
			div_ff <= 9'h000;
		end else if (busy_ff) begin
			div_ff <= div_ff + 9'h001;
		end
	end

	// Remaining slow periods of the pulse
	always_ff @(posedge mclk) begin
		if (reset) begin
			ticks_ff <= 3'h0;
			busy_ff  <= 1'b0;
			done_ff  <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (start) begin
				ticks_ff <= length;
				busy_ff  <= 1'b1;
			end else if (slow_tick) begin
				ticks_ff <= ticks_ff - 3'h1;
				if (ticks_ff == 3'h1) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
			end
		end
	end

	assign busy = busy_ff;
	assign done = done_ff;
endmodule : pgm_pulse_timer
